/* File: design/timer_pair_cfg.svh */
// Offsets, field positions, reset values and divider figures of the timer pair
// Assumes a 12-bit APB byte address and 32-bit data words
`ifndef TIMER_PAIR_CFG_SVH
`define TIMER_PAIR_CFG_SVH

// Register byte offsets
`define TP_ADDR_LOW_MODE 12'h000
`define TP_ADDR_HIGH_MODE 12'h004
`define TP_ADDR_CONTROL 12'h008
`define TP_ADDR_LOW_DUTY 12'h00c
`define TP_ADDR_LOW_CYCLE 12'h010
`define TP_ADDR_HIGH_CYCLE 12'h014
`define TP_ADDR_STATUS 12'h018

// Mode register fields
`define TP_MODE_FIELD_LSB 0
`define TP_MODE_FIELD_MSB 1
`define TP_CLK_SEL_LSB 2
`define TP_CLK_SEL_MSB 4
`define TP_BUF_EN_BIT 5
`define TP_INIT_LEVEL_BIT 6
`define TP_EXT_SEL_BIT 7

// Control register fields
`define TP_LOW_RUN_BIT 0
`define TP_HIGH_RUN_BIT 1
`define TP_CASCADE_BIT 2

// Status register fields
`define TP_STAT_COUNT_MSB 15
`define TP_STAT_LEVEL_BIT 16

// Mode field codes
`define TP_MODE_TIMER_A 2'h0
`define TP_MODE_TIMER_B 2'h1
`define TP_MODE_PPG 2'h2

// Reset values
`define TP_MODE_RESET 8'h00
`define TP_CTRL_RESET 3'h0
`define TP_CMP8_RESET 8'hff
`define TP_CMP16_RESET 16'hffff
`define TP_ZERO8 8'h00
`define TP_ZERO16 16'h0000
`define TP_ZERO32 32'h0000_0000

// Divider shift per clock select code, code 0 slowest
`define TP_DIV_BITS 11
`define TP_SHIFT_SEL0 4'hb
`define TP_SHIFT_SEL1 4'ha
`define TP_SHIFT_SEL2 4'h8
`define TP_SHIFT_SEL3 4'h6
`define TP_SHIFT_SEL4 4'h4
`define TP_SHIFT_SEL5 4'h2
`define TP_SHIFT_SEL6 4'h1
`define TP_SHIFT_SEL7 4'h0

`endif

/* File: design/timer_pair_pkg.sv */
// Types shared by the timer pair files
// Assumes the cfg header is compiled alongside
package timer_pair_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] count_t;
	typedef logic [2:0] clk_sel_t;
	// Operating mode resolved from cascade and mode fields
	typedef enum logic [1:0] {
		OP_IDLE,
		OP_PPG,
		OP_CASCADE
	} op_mode_t;
endpackage

/* File: design/source_tick.sv */
// Source clock divider giving a one-cycle count enable
// Assumes a free-running system clock and a static select while counting
`timescale 1ns/100ps
`default_nettype none
`include "timer_pair_cfg.svh"

module source_tick #(
	parameter int DIV_BITS = `TP_DIV_BITS
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire timer_pair_pkg::clk_sel_t sel,
	output logic tick
);
	import timer_pair_pkg::*;

	logic [DIV_BITS-1:0] div_cnt;
	logic [DIV_BITS-1:0] next_div_cnt;
	logic [DIV_BITS-1:0] mask;

	// Shift amount for a clock select code
	function automatic logic [3:0] shift_of(input clk_sel_t s);
		unique case (s)
			3'h0: shift_of = `TP_SHIFT_SEL0;
			3'h1: shift_of = `TP_SHIFT_SEL1;
			3'h2: shift_of = `TP_SHIFT_SEL2;
			3'h3: shift_of = `TP_SHIFT_SEL3;
			3'h4: shift_of = `TP_SHIFT_SEL4;
			3'h5: shift_of = `TP_SHIFT_SEL5;
			3'h6: shift_of = `TP_SHIFT_SEL6;
			3'h7: shift_of = `TP_SHIFT_SEL7;
		endcase
	endfunction

	// Tick when the low bits of the divider are all ones
	always_comb begin
		next_div_cnt = div_cnt + 1'b1;
		mask = DIV_BITS'(({{(DIV_BITS-1){1'b0}}, 1'b1} << shift_of(sel)) - 1'b1);
		tick = ((div_cnt & mask) == mask);
	end

	// Free-running divider
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end
endmodule

`default_nettype wire

/* File: design/timer_pair.sv */
// Cascadable 8-bit timer pair: low channel pulse mode and 16-bit interval mode
// Assumes an APB master on ref_clk and a port mux outside for the pulse pin
// Contract
// - low buffer enable bit selects compare buffering
// - buffered running writes land in buffer only
// - low match interrupt loads buffered compares
// - low compare reads return buffered value
// - buffered stopped writes update both copies
// - unbuffered writes take effect at once
// - value below count waits for wrap
// - value equal to count matches right away
// - cascade bit joins channels, high settings rule
// - interval mode: high mode 00/01, internal
// - high byte write commits both compare bytes
// - mode writes ignored while channel runs
// - high run counts on selected ticks
// - 16-bit match raises interrupt, clears counter
// - high run cleared stops and zeroes counter
// - high buffer enable bit selects buffering
// - buffered running commit loads at match
// - buffered stopped commit updates both copies
// - unbuffered commit immediate, low value waits
// - commit equal to count matches right away
// - 16-bit compare reads return last written
// - duty match toggles pin, cycle match back
// - low run cleared zeroes, restores level
// - pulse mode: low mode 10, no cascade
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "timer_pair_cfg.svh"

module timer_pair #(
	parameter int ADDR_BITS = 12
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_BITS-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic pulse_output_pin,
	output logic low_match_irq,
	output logic high_match_irq
);
	import timer_pair_pkg::*;

	// Registers
	byte_t low_channel_mode_reg, high_channel_mode_reg;
	logic [2:0] timer_pair_control;
	byte_t low_duty_compare, low_cycle_compare;
	byte_t low_duty_act, low_cycle_act;
	count_t cmp16_buf, cmp16_act;
	count_t cnt;
	logic duty_hit, cycle_hit, hit16;
	byte_t next_low_mode, next_high_mode;
	logic [2:0] next_control;
	byte_t next_low_duty, next_low_cycle, next_low_duty_act, next_low_cycle_act;
	count_t next_cmp16_buf, next_cmp16_act, next_cnt;
	logic next_duty_hit, next_cycle_hit, next_hit16;
	logic next_pin, next_low_irq, next_high_irq;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;

	// Decoded fields
	logic low_run, high_run, cascade_select;
	logic low_buffer_enable, high_buffer_enable, initial_level_select;
	logic high_external_input_select;
	logic [1:0] low_mode_field, high_mode_field;
	clk_sel_t low_clock_select, high_clock_select;
	op_mode_t op_mode;
	logic low_tick, high_tick;
	logic access, wr, rd;
	logic duty_event, cycle_event, event16;
	logic wr_low_mode, wr_high_mode, wr_control, wr_duty, wr_cycle, wr_high_cycle;

	// Address match used by every write strobe
	function automatic logic hit(input logic [ADDR_BITS-1:0] a,
		input logic [ADDR_BITS-1:0] off);
		hit = (a == off);
	endfunction

	// Field extraction
	assign low_run = timer_pair_control[`TP_LOW_RUN_BIT];
	assign high_run = timer_pair_control[`TP_HIGH_RUN_BIT];
	assign cascade_select = timer_pair_control[`TP_CASCADE_BIT];
	assign low_mode_field = low_channel_mode_reg[`TP_MODE_FIELD_MSB:`TP_MODE_FIELD_LSB];
	assign high_mode_field = high_channel_mode_reg[`TP_MODE_FIELD_MSB:`TP_MODE_FIELD_LSB];
	assign low_clock_select = low_channel_mode_reg[`TP_CLK_SEL_MSB:`TP_CLK_SEL_LSB];
	assign high_clock_select = high_channel_mode_reg[`TP_CLK_SEL_MSB:`TP_CLK_SEL_LSB];
	assign low_buffer_enable = low_channel_mode_reg[`TP_BUF_EN_BIT];
	assign high_buffer_enable = high_channel_mode_reg[`TP_BUF_EN_BIT];
	assign initial_level_select = low_channel_mode_reg[`TP_INIT_LEVEL_BIT];
	assign high_external_input_select = high_channel_mode_reg[`TP_EXT_SEL_BIT];

	// Mode resolution; cascade hides every low channel setting except the initial level, which still drives the pin
	always_comb begin
		op_mode = OP_IDLE;
		if (cascade_select) begin
			if ((high_mode_field == `TP_MODE_TIMER_A || high_mode_field == `TP_MODE_TIMER_B)
				&& !high_external_input_select) begin
				op_mode = OP_CASCADE;
			end
		end else if (low_mode_field == `TP_MODE_PPG) begin
			op_mode = OP_PPG;
		end
	end

	// Source clock enables for each channel
	source_tick u_low_tick (
		.ref_clk(ref_clk),
		.rst(rst),
		.sel(low_clock_select),
		.tick(low_tick)
	);

	source_tick u_high_tick (
		.ref_clk(ref_clk),
		.rst(rst),
		.sel(high_clock_select),
		.tick(high_tick)
	);

	// APB strobes; a transfer completes on the edge where pready is high
	assign access = psel && penable && pready;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign wr_low_mode = wr && hit(paddr, `TP_ADDR_LOW_MODE);
	assign wr_high_mode = wr && hit(paddr, `TP_ADDR_HIGH_MODE);
	assign wr_control = wr && hit(paddr, `TP_ADDR_CONTROL);
	assign wr_duty = wr && hit(paddr, `TP_ADDR_LOW_DUTY);
	assign wr_cycle = wr && hit(paddr, `TP_ADDR_LOW_CYCLE);
	assign wr_high_cycle = wr && hit(paddr, `TP_ADDR_HIGH_CYCLE);

	// Match events: equality is checked every clock, so a compare write equal
	// to the count fires at once, off the source tick; only the first cycle
	// of a standing equality counts
	always_comb begin
		next_duty_hit = (op_mode == OP_PPG) && low_run && (cnt[7:0] == low_duty_act);
		next_cycle_hit = (op_mode == OP_PPG) && low_run && (cnt[7:0] == low_cycle_act);
		next_hit16 = (op_mode == OP_CASCADE) && high_run && (cnt == cmp16_act);
		duty_event = next_duty_hit && !duty_hit;
		cycle_event = next_cycle_hit && !cycle_hit;
		event16 = next_hit16 && !hit16;
	end

	// Next register, compare and counter state
	always_comb begin
		next_low_mode = low_channel_mode_reg;
		next_high_mode = high_channel_mode_reg;
		next_control = timer_pair_control;
		next_low_duty = low_duty_compare;
		next_low_cycle = low_cycle_compare;
		next_low_duty_act = low_duty_act;
		next_low_cycle_act = low_cycle_act;
		next_cmp16_buf = cmp16_buf;
		next_cmp16_act = cmp16_act;
		next_cnt = cnt;
		next_pin = pulse_output_pin;
		next_low_irq = 1'b0;
		next_high_irq = 1'b0;
		// Mode registers are locked while their channel runs
		if (wr_low_mode && !low_run) begin
			next_low_mode = pwdata[7:0];
		end
		if (wr_high_mode && !high_run) begin
			next_high_mode = pwdata[7:0];
		end
		if (wr_control) begin
			next_control = pwdata[2:0];
		end
		// Low compare reload at the cycle match when buffered
		if (cycle_event && low_buffer_enable) begin
			next_low_duty_act = low_duty_compare;
			next_low_cycle_act = low_cycle_compare;
		end
		// Low compare writes; the buffer always holds the last written value
		if (wr_duty) begin
			next_low_duty = pwdata[7:0];
			if (!low_buffer_enable || !low_run) begin
				next_low_duty_act = pwdata[7:0];
			end
		end
		if (wr_cycle) begin
			next_low_cycle = pwdata[7:0];
			if (!low_buffer_enable || !low_run) begin
				next_low_cycle_act = pwdata[7:0];
			end
		end
		// 16-bit compare reload at the match when buffered
		if (event16 && high_buffer_enable) begin
			next_cmp16_act = cmp16_buf;
		end
		// High byte write commits both bytes, low byte taken as last written
		if (wr_high_cycle) begin
			next_cmp16_buf = {pwdata[7:0], low_cycle_compare};
			if (!high_buffer_enable || !high_run) begin
				next_cmp16_act = {pwdata[7:0], low_cycle_compare};
			end
		end
		// Counter and pulse pin
		unique case (op_mode)
			OP_CASCADE: begin
				next_pin = initial_level_select;
				if (!high_run) begin
					next_cnt = `TP_ZERO16;
				end else if (event16) begin
					next_cnt = `TP_ZERO16;
					next_high_irq = 1'b1;
				end else if (high_tick) begin
					next_cnt = cnt + 1'b1;
				end
			end
			OP_PPG: begin
				if (!low_run) begin
					next_cnt = `TP_ZERO16;
					next_pin = initial_level_select;
				end else begin
					if (cycle_event) begin
						next_cnt = `TP_ZERO16;
						next_pin = initial_level_select;
						next_low_irq = 1'b1;
					end else begin
						if (duty_event) begin
							next_pin = !initial_level_select;
						end
						if (low_tick) begin
							next_cnt = {`TP_ZERO8, cnt[7:0] + 8'h01};
						end
					end
				end
			end
			OP_IDLE: begin
				next_cnt = `TP_ZERO16;
				next_pin = initial_level_select;
			end
		endcase
	end

	// Register the timer state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_channel_mode_reg <= `TP_MODE_RESET;
			high_channel_mode_reg <= `TP_MODE_RESET;
			timer_pair_control <= `TP_CTRL_RESET;
			low_duty_compare <= `TP_CMP8_RESET;
			low_cycle_compare <= `TP_CMP8_RESET;
			low_duty_act <= `TP_CMP8_RESET;
			low_cycle_act <= `TP_CMP8_RESET;
			cmp16_buf <= `TP_CMP16_RESET;
			cmp16_act <= `TP_CMP16_RESET;
			cnt <= `TP_ZERO16;
			duty_hit <= 1'b0;
			cycle_hit <= 1'b0;
			hit16 <= 1'b0;
			pulse_output_pin <= 1'b0;
			low_match_irq <= 1'b0;
			high_match_irq <= 1'b0;
		end else begin
			low_channel_mode_reg <= next_low_mode;
			high_channel_mode_reg <= next_high_mode;
			timer_pair_control <= next_control;
			low_duty_compare <= next_low_duty;
			low_cycle_compare <= next_low_cycle;
			low_duty_act <= next_low_duty_act;
			low_cycle_act <= next_low_cycle_act;
			cmp16_buf <= next_cmp16_buf;
			cmp16_act <= next_cmp16_act;
			cnt <= next_cnt;
			duty_hit <= next_duty_hit;
			cycle_hit <= next_cycle_hit;
			hit16 <= next_hit16;
			pulse_output_pin <= next_pin;
			low_match_irq <= next_low_irq;
			high_match_irq <= next_high_irq;
		end
	end

	// APB answer: one wait state, registered read data, error on unmapped
	always_comb begin
		next_pready = psel && penable && !pready;
		next_prdata = `TP_ZERO32;
		next_pslverr = 1'b0;
		if (psel && penable && !pready) begin
			unique case (paddr)
				`TP_ADDR_LOW_MODE: next_prdata = {24'h00_0000, low_channel_mode_reg};
				`TP_ADDR_HIGH_MODE: next_prdata = {24'h00_0000, high_channel_mode_reg};
				`TP_ADDR_CONTROL: next_prdata = {29'h0000_0000, timer_pair_control};
				`TP_ADDR_LOW_DUTY: next_prdata = {24'h00_0000, low_duty_compare};
				`TP_ADDR_LOW_CYCLE: next_prdata = {24'h00_0000, low_cycle_compare};
				`TP_ADDR_HIGH_CYCLE: next_prdata = {24'h00_0000, cmp16_buf[15:8]};
				`TP_ADDR_STATUS: begin
					next_prdata[`TP_STAT_COUNT_MSB:0] = cnt;
					next_prdata[`TP_STAT_LEVEL_BIT] = pulse_output_pin;
				end
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	// Register the bus answer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= `TP_ZERO32;
			pslverr <= 1'b0;
		end else begin
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// Checks on the timer behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_stop16;
		(op_mode == OP_CASCADE) && !high_run |=> (cnt == `TP_ZERO16);
	endproperty
	a_stop16: assert property (p_stop16) else $error("16-bit count not zero when stopped");

	property p_match16;
		$rose(high_match_irq) |-> (cnt == `TP_ZERO16) && $past(cnt) == $past(cmp16_act);
	endproperty
	a_match16: assert property (p_match16) else $error("16-bit match did not clear count");

	// Pin follows the level chosen in the cycle before, so a stopped mode write lags one clock
	property p_low_stop;
		(op_mode == OP_PPG) && !low_run
			|=> pulse_output_pin == $past(initial_level_select) && cnt == `TP_ZERO16;
	endproperty
	a_low_stop: assert property (p_low_stop) else $error("Stopped pin or count wrong");

	property p_buf_hold;
		wr_duty && low_buffer_enable && low_run && !cycle_event |=> $stable(low_duty_act);
	endproperty
	a_buf_hold: assert property (p_buf_hold) else $error("Buffered write reached active");

	property p_buf_stopped;
		wr_duty && low_buffer_enable && !low_run
			|=> low_duty_act == $past(pwdata[7:0]) && low_duty_compare == low_duty_act;
	endproperty
	a_buf_stopped: assert property (p_buf_stopped) else $error("Stopped write missed a copy");

	property p_unbuf;
		wr_cycle && !low_buffer_enable |=> low_cycle_act == $past(pwdata[7:0]);
	endproperty
	a_unbuf: assert property (p_unbuf) else $error("Unbuffered write not immediate");

	property p_reload;
		cycle_event && low_buffer_enable && !wr_duty |=> low_duty_act == $past(low_duty_compare);
	endproperty
	a_reload: assert property (p_reload) else $error("Buffered duty not reloaded");

	property p_commit;
		wr_high_cycle && !(high_buffer_enable && high_run)
			|=> cmp16_act == {$past(pwdata[7:0]), $past(low_cycle_compare)};
	endproperty
	a_commit: assert property (p_commit) else $error("16-bit commit wrong");

	property p_equal16;
		wr_high_cycle && !high_buffer_enable && high_run && (op_mode == OP_CASCADE)
			&& !high_tick && cnt != cmp16_act && {pwdata[7:0], low_cycle_compare} == cnt
			|=> ##1 high_match_irq;
	endproperty
	a_equal16: assert property (p_equal16) else $error("Equal commit did not match at once");

	property p_mode_lock;
		wr_high_mode && high_run |=> $stable(high_channel_mode_reg);
	endproperty
	a_mode_lock: assert property (p_mode_lock) else $error("Mode write taken while running");

	property p_read16;
		rd && hit(paddr, `TP_ADDR_HIGH_CYCLE) |-> prdata[7:0] == cmp16_buf[15:8];
	endproperty
	a_read16: assert property (p_read16) else $error("High compare read wrong");

	c_ppg_cycle: cover property (low_match_irq ##[1:600] low_match_irq);
	c_match16: cover property (high_match_irq);
	c_buffered_write: cover property (wr_high_cycle && high_buffer_enable && high_run);
	c_equal_write: cover property (wr_duty && !low_buffer_enable ##1 duty_event);
endmodule

`default_nettype wire

/* File: sim/pulse_pin_model.sv */
// Receiver on the pulse output pin: measures the length of each high phase
// Assumes the pin is sampled on the rising edge of the system clock
`timescale 1ns/100ps
`default_nettype none

module pulse_pin_model (
	input wire logic ref_clk,
	input wire logic pin,
	output int high_len
);
	int run = 0;

	// Length of the last completed high phase, in clocks
	always @(posedge ref_clk) begin
		if (pin === 1'b1) begin
			run++;
		end else begin
			if (run != 0) begin
				high_len = run;
			end
			run = 0;
		end
	end
endmodule
`default_nettype wire

/* File: sim/timer_pair_tb.sv */
// Self-checking bench: pulse mode, compare buffering and cascaded interval mode
// Assumes the design header, package and modules are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "timer_pair_cfg.svh"

module timer_pair_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pulse_output_pin;
	logic low_match_irq;
	logic high_match_irq;
	logic err_seen;
	int high_len;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	int cnt[2] = '{0, 0};
	int gl[$];
	int gh[$];

	timer_pair #(.ADDR_BITS(12)) dut (
		.ref_clk(ref_clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.pulse_output_pin(pulse_output_pin),
		.low_match_irq(low_match_irq),
		.high_match_irq(high_match_irq)
	);

	pulse_pin_model pin_rx (
		.ref_clk(ref_clk),
		.pin(pulse_output_pin),
		.high_len(high_len)
	);

	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;

	// Cycle gaps between match pulses, plus the hang limit
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			report_and_stop();
		end
		if (low_match_irq === 1'b1) begin
			gl.push_back(cnt[0]);
			cnt[0] = 1;
		end else begin
			cnt[0]++;
		end
		if (high_match_irq === 1'b1) begin
			gh.push_back(cnt[1]);
			cnt[1] = 1;
		end else begin
			cnt[1]++;
		end
	end

	task automatic report_and_stop();
		if (errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		apb(1'b1, a, {24'h00_0000, d}, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] q;
		apb(1'b0, a, 32'h0000_0000, q);
		chk(q & m, e);
	endtask

	// Gap before match pulse number k of a channel; -1 if it does not come within 1000 clocks
	task automatic nth(input logic hi, input int k, output int gap);
		int n;
		n = 0;
		while ((hi ? gh.size() : gl.size()) <= k && n < 1000) begin
			@(posedge ref_clk);
			n++;
		end
		gap = (hi ? gh.size() : gl.size()) > k ? (hi ? gh[k] : gl[k]) : -1;
	endtask

	task automatic t_reset();
		rd(`TP_ADDR_LOW_DUTY, 32'h0000_00ff, 32'hffff_ffff);
		rd(`TP_ADDR_LOW_CYCLE, 32'h0000_00ff, 32'hffff_ffff);
		rd(`TP_ADDR_HIGH_CYCLE, 32'h0000_00ff, 32'hffff_ffff);
		rd(`TP_ADDR_LOW_MODE, 32'h0000_0000, 32'hffff_ffff);
		rd(`TP_ADDR_HIGH_MODE, 32'h0000_0000, 32'hffff_ffff);
		rd(`TP_ADDR_CONTROL, 32'h0000_0000, 32'hffff_ffff);
		rd(12'h01c, 32'h0000_0000, 32'hffff_ffff);
		chk({31'h0000_0000, err_seen}, 32'h0000_0001);
	endtask

	// Unbuffered pulse mode: period, duty, late write, write below count, stop
	task automatic t_ppg();
		int k;
		int g;
		wr(`TP_ADDR_LOW_MODE, 8'h1e);
		wr(`TP_ADDR_LOW_DUTY, 8'h04);
		wr(`TP_ADDR_LOW_CYCLE, 8'h08);
		k = gl.size();
		wr(`TP_ADDR_CONTROL, 8'h01);
		nth(1'b0, k + 1, g);
		chk(g, 32'h0000_0009);
		chk(high_len, 32'h0000_0004);
		wr(`TP_ADDR_LOW_CYCLE, 8'h20);
		nth(1'b0, k + 2, g);
		chk(g, 32'h0000_0021);
		repeat (20) @(posedge ref_clk);
		wr(`TP_ADDR_LOW_CYCLE, 8'h10);
		nth(1'b0, k + 3, g);
		chk(g, 32'h0000_0111);
		wr(`TP_ADDR_LOW_MODE, 8'h00);
		rd(`TP_ADDR_LOW_MODE, 32'h0000_001e, 32'h0000_00ff);
		wr(`TP_ADDR_CONTROL, 8'h00);
		rd(`TP_ADDR_STATUS, 32'h0000_0000, 32'h0001_ffff);
		wr(`TP_ADDR_LOW_MODE, 8'h5e);
		k = gl.size();
		wr(`TP_ADDR_CONTROL, 8'h01);
		nth(1'b0, k, g);
		wr(`TP_ADDR_CONTROL, 8'h00);
		rd(`TP_ADDR_STATUS, 32'h0001_0000, 32'h0001_ffff);
		chk({31'h0000_0000, pulse_output_pin}, 32'h0000_0001);
	endtask

	// Buffered pulse mode: stopped write both, running write deferred
	task automatic t_ppg_buf();
		int k;
		int g;
		wr(`TP_ADDR_LOW_MODE, 8'h3e);
		wr(`TP_ADDR_LOW_DUTY, 8'h02);
		wr(`TP_ADDR_LOW_CYCLE, 8'h08);
		k = gl.size();
		wr(`TP_ADDR_CONTROL, 8'h01);
		nth(1'b0, k + 1, g);
		chk(g, 32'h0000_0009);
		wr(`TP_ADDR_LOW_CYCLE, 8'h20);
		rd(`TP_ADDR_LOW_CYCLE, 32'h0000_0020, 32'h0000_00ff);
		nth(1'b0, k + 2, g);
		chk(g, 32'h0000_0009);
		@(posedge ref_clk);
		chk(high_len, 32'h0000_0006);
		nth(1'b0, k + 3, g);
		chk(g, 32'h0000_0021);
		wr(`TP_ADDR_LOW_DUTY, 8'h10);
		rd(`TP_ADDR_LOW_DUTY, 32'h0000_0010, 32'h0000_00ff);
		nth(1'b0, k + 4, g);
		chk(g, 32'h0000_0021);
		nth(1'b0, k + 5, g);
		@(posedge ref_clk);
		chk(high_len, 32'h0000_0010);
		wr(`TP_ADDR_CONTROL, 8'h00);
	endtask

	// Cascaded interval mode, unbuffered, low channel run bit ignored
	task automatic t_cascade();
		int k;
		int j;
		int g;
		wr(`TP_ADDR_HIGH_MODE, 8'h1c);
		wr(`TP_ADDR_LOW_CYCLE, 8'h10);
		wr(`TP_ADDR_HIGH_CYCLE, 8'h00);
		k = gh.size();
		j = gl.size();
		wr(`TP_ADDR_CONTROL, 8'h07);
		nth(1'b1, k + 1, g);
		chk(g, 32'h0000_0011);
		wr(`TP_ADDR_LOW_CYCLE, 8'h00);
		wr(`TP_ADDR_HIGH_CYCLE, 8'h01);
		nth(1'b1, k + 2, g);
		chk(g, 32'h0000_0101);
		chk(gl.size(), j);
		wr(`TP_ADDR_HIGH_MODE, 8'h00);
		rd(`TP_ADDR_HIGH_MODE, 32'h0000_001c, 32'h0000_00ff);
		rd(`TP_ADDR_HIGH_CYCLE, 32'h0000_0001, 32'h0000_00ff);
		wr(`TP_ADDR_CONTROL, 8'h04);
		rd(`TP_ADDR_STATUS, 32'h0000_0000, 32'h0000_ffff);
	endtask

	// Cascaded interval mode with the 16-bit compare buffered
	task automatic t_cascade_buf();
		int k;
		int g;
		wr(`TP_ADDR_CONTROL, 8'h00);
		wr(`TP_ADDR_HIGH_MODE, 8'h3d);
		wr(`TP_ADDR_LOW_CYCLE, 8'h10);
		wr(`TP_ADDR_HIGH_CYCLE, 8'h00);
		k = gh.size();
		wr(`TP_ADDR_CONTROL, 8'h06);
		nth(1'b1, k + 1, g);
		chk(g, 32'h0000_0011);
		wr(`TP_ADDR_LOW_CYCLE, 8'h20);
		wr(`TP_ADDR_HIGH_CYCLE, 8'h00);
		nth(1'b1, k + 2, g);
		chk(g, 32'h0000_0011);
		nth(1'b1, k + 3, g);
		chk(g, 32'h0000_0021);
		rd(`TP_ADDR_LOW_CYCLE, 32'h0000_0020, 32'h0000_00ff);
		wr(`TP_ADDR_CONTROL, 8'h00);
	endtask

	// Slow source clock: a compare written equal to the held count matches at once
	task automatic t_equal();
		int k;
		logic [31:0] q;
		wr(`TP_ADDR_HIGH_MODE, 8'h00);
		wr(`TP_ADDR_LOW_CYCLE, 8'hff);
		wr(`TP_ADDR_HIGH_CYCLE, 8'hff);
		wr(`TP_ADDR_CONTROL, 8'h06);
		do begin
			apb(1'b0, `TP_ADDR_STATUS, 32'h0000_0000, q);
		end while (q[15:0] !== 16'h0001);
		k = gh.size();
		wr(`TP_ADDR_LOW_CYCLE, 8'h01);
		wr(`TP_ADDR_HIGH_CYCLE, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk(gh.size(), k + 1);
		wr(`TP_ADDR_CONTROL, 8'h00);
		wr(`TP_ADDR_LOW_MODE, 8'h02);
		wr(`TP_ADDR_LOW_DUTY, 8'hff);
		wr(`TP_ADDR_LOW_CYCLE, 8'hff);
		wr(`TP_ADDR_CONTROL, 8'h01);
		do begin
			apb(1'b0, `TP_ADDR_STATUS, 32'h0000_0000, q);
		end while (q[7:0] !== 8'h01);
		wr(`TP_ADDR_LOW_DUTY, 8'h01);
		repeat (2) @(posedge ref_clk);
		chk({31'h0000_0000, pulse_output_pin}, 32'h0000_0001);
		wr(`TP_ADDR_CONTROL, 8'h00);
	endtask

	// Reset, then the scenarios in turn
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_ppg();
		t_ppg_buf();
		t_cascade();
		t_cascade_buf();
		t_equal();
		report_and_stop();
	end
endmodule
`default_nettype wire
